// [common/acf_pkg.sv]
// constants for the add/carry datapath, core registers and condition flags
package acf_pkg;
  localparam int unsigned ACF_DW = 32;
  localparam int unsigned ACF_IDXW = 4;
  localparam int unsigned ACF_NUM_WR = 15;
  localparam logic [3:0] ACF_IDX_SP = 4'hd;
  localparam logic [3:0] ACF_IDX_LR = 4'he;
  localparam logic [3:0] ACF_IDX_PC = 4'hf;
  localparam logic [31:0] ACF_PC_STEP = 32'h0000_0002;
  localparam logic [31:0] ACF_GPR_RST = 32'h0000_0000;
  // flag bit positions inside the program status word
  localparam int unsigned ACF_N_BIT = 31;
  localparam int unsigned ACF_Z_BIT = 30;
  localparam int unsigned ACF_C_BIT = 29;
  localparam int unsigned ACF_V_BIT = 28;
  // flag select vector positions (upd[3]=n ... upd[0]=v)
  localparam int unsigned ACF_UPD_N = 3;
  localparam int unsigned ACF_UPD_Z = 2;
  localparam int unsigned ACF_UPD_C = 1;
  localparam int unsigned ACF_UPD_V = 0;
  localparam int unsigned ACF_STATE_BIT = 24;
  // apb register byte offsets
  localparam int unsigned ACF_AW = 8;
  localparam logic [7:0] ACF_OFS_FLAGS = 8'h00;
  localparam logic [7:0] ACF_OFS_STATUS = 8'h04;
  localparam logic [7:0] ACF_OFS_CLEAR = 8'h08;
  localparam logic [7:0] ACF_OFS_ENABLE = 8'h0c;
  localparam logic [7:0] ACF_OFS_VIEW_IDX = 8'h10;
  localparam logic [7:0] ACF_OFS_VIEW_DATA = 8'h14;
  localparam logic [7:0] ACF_OFS_STATE = 8'h18;
  // event status bits
  localparam int unsigned ACF_EVW = 4;
  localparam int unsigned ACF_EV_OVF = 0;
  localparam int unsigned ACF_EV_PCWR = 1;
  localparam int unsigned ACF_EV_EXC = 2;
  localparam int unsigned ACF_EV_IRQ = 3;
  typedef enum logic [1:0] {
    ACF_BR_SIMPLE = 2'b00,
    ACF_BR_LINK = 2'b01,
    ACF_BR_LOAD = 2'b10,
    ACF_BR_ALU = 2'b11
  } acf_br_e;
endpackage : acf_pkg

// [rtl/acf_core.sv]
// add/carry datapath, core register file, condition flags and apb view
`timescale 1ns/10ps
module acf_core
  import acf_pkg::*;
#(
  parameter logic [31:0] P_SP_RESET = 32'h2000_1000,
  parameter logic [31:0] P_PC_RESET = 32'h0000_0100
)(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // datapath request
  input wire logic i_op_valid,
  input wire logic i_op_sub,
  input wire logic [acf_pkg::ACF_DW-1:0] i_op_a,
  input wire logic [acf_pkg::ACF_DW-1:0] i_op_b,
  input wire logic i_op_cin,
  input wire logic [3:0] i_op_flag_upd,
  input wire logic i_op_wr_en,
  input wire logic [acf_pkg::ACF_IDXW-1:0] i_op_wr_idx,
  // load result write
  input wire logic i_ld_valid,
  input wire logic [acf_pkg::ACF_IDXW-1:0] i_ld_idx,
  input wire logic [acf_pkg::ACF_DW-1:0] i_ld_data,
  // branches and exception entry
  input wire logic i_br_valid,
  input wire acf_pkg::acf_br_e i_br_kind,
  input wire logic [acf_pkg::ACF_DW-1:0] i_br_target,
  input wire logic [acf_pkg::ACF_DW-1:0] i_br_ret,
  input wire logic i_exc_entry,
  input wire logic [acf_pkg::ACF_DW-1:0] i_exc_lr,
  input wire logic [acf_pkg::ACF_DW-1:0] i_exc_vector,
  input wire logic i_pc_advance,
  input wire logic i_irq_async,
  // register read port
  input wire logic [acf_pkg::ACF_IDXW-1:0] i_rd_idx,
  output logic [acf_pkg::ACF_DW-1:0] o_rd_data,
  // datapath answer
  output logic o_op_done,
  output logic [acf_pkg::ACF_DW-1:0] o_op_result,
  output logic o_op_carry,
  output logic o_op_ovf,
  output logic [3:0] o_flags,
  output logic [acf_pkg::ACF_DW-1:0] o_pc,
  output logic [acf_pkg::ACF_DW-1:0] o_sp,
  output logic o_compact_state,
  output logic o_irq,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acf_pkg::ACF_AW-1:0] paddr,
  input wire logic [acf_pkg::ACF_DW-1:0] pwdata,
  output logic [acf_pkg::ACF_DW-1:0] prdata,
  output logic pready,
  output logic pslverr
);
  import acf_pkg::*;

  logic [ACF_DW-1:0] gpr_r [0:ACF_NUM_WR-1];
  logic [ACF_DW-1:0] pc_r;
  logic [3:0] flags_r;
  logic [ACF_EVW-1:0] status_r;
  logic [ACF_EVW-1:0] enable_r;
  logic [ACF_IDXW-1:0] view_idx_r;
  logic [ACF_DW-1:0] rd_data_r;
  logic op_done_r;
  logic [ACF_DW-1:0] result_r;
  logic carry_r;
  logic ovf_r;
  logic irq_r;
  logic state_r;
  logic irq_meta_r;
  logic irq_sync_r;
  logic irq_sync_d_r;
  logic [ACF_DW-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // add with carry: one adder serves add and subtract
  logic [ACF_DW-1:0] opnd_b;
  logic [ACF_DW:0] usum;
  logic [ACF_DW-1:0] sum_nxt;
  logic carry_nxt;
  logic ovf_nxt;
  assign opnd_b = i_op_sub ? ~i_op_b : i_op_b;
  assign usum = {1'b0, i_op_a} + {1'b0, opnd_b} + {{ACF_DW{1'b0}}, i_op_cin};
  assign sum_nxt = usum[ACF_DW-1:0];
  // carry out is the bit that does not fit: unsigned result differs from true sum
  assign carry_nxt = usum[ACF_DW];
  // signed overflow: operands agree in sign and result does not
  assign ovf_nxt = (i_op_a[ACF_DW-1] == opnd_b[ACF_DW-1])
                   && (sum_nxt[ACF_DW-1] != i_op_a[ACF_DW-1]);

  // apb decode
  logic apb_acc;
  logic apb_wr;
  logic addr_ok;
  assign apb_acc = psel && penable && !pready_r;
  assign apb_wr = psel && penable && pready_r && pwrite; // lands on the edge pready is seen
  assign addr_ok = (paddr == ACF_OFS_FLAGS) || (paddr == ACF_OFS_STATUS)
                   || (paddr == ACF_OFS_CLEAR) || (paddr == ACF_OFS_ENABLE)
                   || (paddr == ACF_OFS_VIEW_IDX) || (paddr == ACF_OFS_VIEW_DATA)
                   || (paddr == ACF_OFS_STATE);

  // indexed read: index 15 returns the program counter
  function automatic logic [ACF_DW-1:0] rd_reg(input logic [ACF_IDXW-1:0] idx);
    return (idx == ACF_IDX_PC) ? pc_r : gpr_r[idx];
  endfunction : rd_reg

  // counter write arbitration, highest priority first
  logic pc_wr;
  logic [ACF_DW-1:0] pc_wr_val;
  always_comb
  begin
    pc_wr = 1'b1;
    pc_wr_val = i_br_target;
    if (i_exc_entry)
    begin
      pc_wr_val = i_exc_vector;
    end
    else if (i_br_valid)
    begin
      pc_wr_val = i_br_target;
    end
    else if (i_op_valid && i_op_wr_en && (i_op_wr_idx == ACF_IDX_PC))
    begin
      pc_wr_val = sum_nxt;
    end
    else if (i_ld_valid && (i_ld_idx == ACF_IDX_PC))
    begin
      pc_wr_val = i_ld_data;
    end
    else
    begin
      pc_wr = 1'b0;
    end
  end

  // program counter: every write is a simple branch, bit zero forced low
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pc_r <= P_PC_RESET;
    else if (pc_wr)
      pc_r <= {pc_wr_val[ACF_DW-1:1], 1'b0};
    else if (i_pc_advance)
      pc_r <= pc_r + ACF_PC_STEP;
  end

  // one process per writable register; index 15 never lands here
  genvar gi;
  generate
    for (gi = 0; gi < ACF_NUM_WR; gi++)
    begin : g_gpr
      localparam logic [ACF_IDXW-1:0] LI = ACF_IDXW'(gi);
      localparam logic [ACF_DW-1:0] RV = (LI == ACF_IDX_SP) ? P_SP_RESET : ACF_GPR_RST;
      always_ff @(posedge i_clk_sys or negedge i_arst_n)
      begin
        if (!i_arst_n)
          gpr_r[gi] <= RV;
        else if ((LI == ACF_IDX_LR) && i_exc_entry)
          gpr_r[gi] <= i_exc_lr;
        else if ((LI == ACF_IDX_LR) && i_br_valid && (i_br_kind == ACF_BR_LINK))
          gpr_r[gi] <= i_br_ret;
        else if (i_op_valid && i_op_wr_en && (i_op_wr_idx == LI))
          gpr_r[gi] <= sum_nxt;
        else if (i_ld_valid && (i_ld_idx == LI))
          gpr_r[gi] <= i_ld_data;
      end
    end
  endgenerate

  // condition flags; datapath update wins over a same-cycle software write
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      flags_r <= 4'h0;
    end
    else if (i_op_valid)
    begin
      if (i_op_flag_upd[ACF_UPD_N])
        flags_r[ACF_UPD_N] <= sum_nxt[ACF_N_BIT];
      if (i_op_flag_upd[ACF_UPD_Z])
        flags_r[ACF_UPD_Z] <= (sum_nxt == ACF_GPR_RST);
      if (i_op_flag_upd[ACF_UPD_C])
        flags_r[ACF_UPD_C] <= carry_nxt;
      if (i_op_flag_upd[ACF_UPD_V])
        flags_r[ACF_UPD_V] <= ovf_nxt;
    end
    else if (apb_wr && (paddr == ACF_OFS_FLAGS))
    begin
      // reserved bits are dropped; software keeps them itself
      flags_r <= pwdata[ACF_N_BIT:ACF_V_BIT];
    end
  end

  // datapath answer registers
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      op_done_r <= 1'b0;
      result_r <= ACF_GPR_RST;
      carry_r <= 1'b0;
      ovf_r <= 1'b0;
    end
    else
    begin
      op_done_r <= i_op_valid;
      if (i_op_valid)
      begin
        result_r <= sum_nxt;
        carry_r <= carry_nxt;
        ovf_r <= ovf_nxt;
      end
    end
  end

  // read port, one cycle latency
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_data_r <= ACF_GPR_RST;
    end
    else
    begin
      rd_data_r <= rd_reg(i_rd_idx);
    end
  end

  // interrupt pin crosses in by two flops; a third flop delays the second so its rising edge can be found
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      irq_meta_r <= 1'b0;
      irq_sync_r <= 1'b0;
      irq_sync_d_r <= 1'b0;
    end
    else
    begin
      irq_meta_r <= i_irq_async;
      irq_sync_r <= irq_meta_r;
      irq_sync_d_r <= irq_sync_r;
    end
  end

  // sticky events; a set in the clearing cycle survives
  logic [ACF_EVW-1:0] ev_set;
  logic [ACF_EVW-1:0] ev_clr;
  always_comb
  begin
    ev_set = '0;
    ev_set[ACF_EV_OVF] = i_op_valid && ovf_nxt;
    ev_set[ACF_EV_PCWR] = pc_wr && !i_exc_entry && !i_br_valid;
    ev_set[ACF_EV_EXC] = i_exc_entry;
    ev_set[ACF_EV_IRQ] = irq_sync_r && !irq_sync_d_r;
    ev_clr = '0;
    if (apb_wr && (paddr == ACF_OFS_CLEAR))
      ev_clr = pwdata[ACF_EVW-1:0];
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      status_r <= '0;
    end
    else
    begin
      status_r <= (status_r & ~ev_clr) | ev_set;
    end
  end

  // software controls: interrupt enable and view index
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      enable_r <= '0;
      view_idx_r <= '0;
    end
    else if (apb_wr)
    begin
      if (paddr == ACF_OFS_ENABLE)
        enable_r <= pwdata[ACF_EVW-1:0];
      if (paddr == ACF_OFS_VIEW_IDX)
        view_idx_r <= pwdata[ACF_IDXW-1:0];
    end
  end

  // interrupt level lags status by one cycle to stay registered
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      irq_r <= 1'b0;
      state_r <= 1'b0;
    end
    else
    begin
      irq_r <= |(status_r & enable_r);
      state_r <= 1'b1;
    end
  end

  // apb answer: one wait state, unmapped addresses flag an error
  logic [ACF_DW-1:0] rdata_nxt;
  always_comb
  begin
    rdata_nxt = '0;
    case (paddr)
      ACF_OFS_FLAGS: rdata_nxt[ACF_N_BIT:ACF_V_BIT] = flags_r;
      ACF_OFS_STATUS: rdata_nxt[ACF_EVW-1:0] = status_r;
      ACF_OFS_ENABLE: rdata_nxt[ACF_EVW-1:0] = enable_r;
      ACF_OFS_VIEW_IDX: rdata_nxt[ACF_IDXW-1:0] = view_idx_r;
      ACF_OFS_VIEW_DATA: rdata_nxt = rd_reg(view_idx_r);
      ACF_OFS_STATE: rdata_nxt[ACF_STATE_BIT] = state_r;
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= apb_acc;
      pslverr_r <= apb_acc && !addr_ok;
      if (apb_acc && !pwrite)
        prdata_r <= rdata_nxt;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_op_done = op_done_r;
  assign o_op_result = result_r;
  assign o_op_carry = carry_r;
  assign o_op_ovf = ovf_r;
  assign o_flags = flags_r;
  assign o_pc = pc_r;
  assign o_sp = gpr_r[ACF_IDX_SP];
  assign o_compact_state = state_r;
  assign o_irq = irq_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  logic [ACF_DW:0] chk_sum;
  assign chk_sum = {1'b0, i_op_a} + {1'b0, (i_op_sub ? ~i_op_b : i_op_b)}
                   + {{ACF_DW{1'b0}}, i_op_cin};

  a_add_result: assert property (
    i_op_valid |=> o_op_done && (o_op_result == $past(chk_sum[ACF_DW-1:0])))
    else $error("adder result wrong");
  a_carry_out: assert property (
    i_op_valid && !i_op_sub |=> o_op_carry == ($past(i_op_a) + $past(i_op_b)
      + $past(i_op_cin) > 64'(32'hffff_ffff)))
    else $error("carry out wrong");
  a_ovf_out: assert property (
    i_op_valid |=> o_op_ovf == ((($past(i_op_a) ^ o_op_result)
      & ($past(i_op_sub ? ~i_op_b : i_op_b) ^ o_op_result)) >> (ACF_DW - 1)))
    else $error("overflow out wrong");
  a_sub_borrow: assert property (
    i_op_valid && i_op_sub && i_op_cin |=> o_op_carry == ($past(i_op_a) >= $past(i_op_b)))
    else $error("borrow wrong");
  a_branch_lsb: assert property (
    i_br_valid && !i_exc_entry |=> o_pc == {$past(i_br_target[ACF_DW-1:1]), 1'b0})
    else $error("branch target wrong");
  a_zero_flag: assert property (
    i_op_valid && i_op_flag_upd[ACF_UPD_Z] |=> o_flags[ACF_UPD_Z] == (o_op_result == '0))
    else $error("zero flag wrong");
  a_neg_hold: assert property (
    i_op_valid && !i_op_flag_upd[ACF_UPD_N] |=> $stable(o_flags[ACF_UPD_N]))
    else $error("negative flag changed");
  a_link_write: assert property (
    i_br_valid && (i_br_kind == ACF_BR_LINK) && !i_exc_entry
      |=> gpr_r[ACF_IDX_LR] == $past(i_br_ret))
    else $error("link not written");
  sequence s_apb_access;
    psel && penable && !pready;
  endsequence
  a_apb_answer: assert property (
    s_apb_access |=> pready ##1 !pready)
    else $error("apb answer timing");
  a_irq_level: assert property (
    (|(status_r & enable_r)) |=> o_irq)
    else $error("interrupt not raised");
endmodule : acf_core

// [sim/acf_ctl_model.sv]
// control-side model issuing datapath requests one at a time
`timescale 1ns/10ps
module acf_ctl_model
  import acf_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_op_done,
  output logic o_op_valid,
  output logic o_op_sub,
  output logic [acf_pkg::ACF_DW-1:0] o_op_a,
  output logic [acf_pkg::ACF_DW-1:0] o_op_b,
  output logic o_op_cin,
  output logic [3:0] o_op_flag_upd,
  output logic o_op_wr_en,
  output logic [3:0] o_op_wr_idx
);
  int n;
  // idle request at time zero
  initial
  begin
    o_op_valid = 1'b0;
    o_op_sub = 1'b0;
    o_op_a = '0;
    o_op_b = '0;
    o_op_cin = 1'b0;
    o_op_flag_upd = 4'h0;
    o_op_wr_en = 1'b0;
    o_op_wr_idx = 4'h0;
  end
  // one-cycle request; operands inverted after so stale data never looks valid
  task automatic issue(input logic s, input logic [31:0] a, input logic [31:0] b,
      input logic ci, input logic [3:0] upd, input logic we, input logic [3:0] idx);
    @(posedge i_clk_sys);
    o_op_valid <= 1'b1;
    o_op_sub <= s;
    o_op_a <= a;
    o_op_b <= b;
    o_op_cin <= ci;
    o_op_flag_upd <= upd;
    o_op_wr_en <= we;
    o_op_wr_idx <= idx;
    @(posedge i_clk_sys);
    o_op_valid <= 1'b0;
    o_op_wr_en <= 1'b0;
    o_op_a <= ~a;
    o_op_b <= ~b;
    #1;
    n = 0;
    // bounded wait for the answer pulse
    while (i_op_done !== 1'b1 && n < 4)
    begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
  endtask : issue
endmodule : acf_ctl_model

// [sim/tb_add_carry_flags_core_regs.sv]
// bench for the add/carry datapath, core registers, flags and apb view
`timescale 1ns/10ps
module tb_add_carry_flags_core_regs;
  import acf_pkg::*;
  localparam logic [31:0] SP_TOP = 32'h2000_0400;
  localparam logic [31:0] PC_START = 32'h0000_0200;
  typedef struct packed {
    logic s;
    logic [31:0] a;
    logic [31:0] b;
    logic ci;
    logic [31:0] r;
    logic co;
    logic ov;
  } acf_row_s;
  // adder rows: carries, borrows, zero results and signed overflows
  acf_row_s rows [8] = '{
    '{1'b0, 32'h7fff_ffff, 32'h0000_0001, 1'b0, 32'h8000_0000, 1'b0, 1'b1},
    '{1'b0, 32'hffff_ffff, 32'h0000_0001, 1'b0, 32'h0000_0000, 1'b1, 1'b0},
    '{1'b0, 32'hffff_ffff, 32'h0000_0000, 1'b1, 32'h0000_0000, 1'b1, 1'b0},
    '{1'b0, 32'h8000_0000, 32'h8000_0000, 1'b0, 32'h0000_0000, 1'b1, 1'b1},
    '{1'b1, 32'h0000_0005, 32'h0000_0003, 1'b1, 32'h0000_0002, 1'b1, 1'b0},
    '{1'b1, 32'h0000_0003, 32'h0000_0005, 1'b1, 32'hffff_fffe, 1'b0, 1'b0},
    '{1'b1, 32'h0000_0005, 32'h0000_0005, 1'b0, 32'hffff_ffff, 1'b0, 1'b0},
    '{1'b1, 32'h8000_0000, 32'h0000_0001, 1'b1, 32'h7fff_ffff, 1'b1, 1'b1}
  };
  logic clk, rst_n, op_valid, op_sub, op_cin, op_wr_en, op_done, op_carry, op_ovf;
  logic ld_valid, br_valid, exc_entry, irq_pin, cstate, irq, e, pc_adv;
  logic psel, penable, pwrite, pready, pslverr;
  logic [3:0] op_upd, op_idx, ld_idx, rd_idx, flags;
  logic [7:0] paddr;
  logic [31:0] op_a, op_b, ld_data, br_target, br_ret, exc_lr, exc_vec, rd_data;
  logic [31:0] op_res, pc, sp, pwdata, prdata, v;
  acf_br_e br_kind;
  int err_total, num_checks;

  acf_core #(.P_SP_RESET(SP_TOP), .P_PC_RESET(PC_START)) u_acf_core (
    .i_clk_sys(clk), .i_arst_n(rst_n), .i_op_valid(op_valid), .i_op_sub(op_sub),
    .i_op_a(op_a), .i_op_b(op_b), .i_op_cin(op_cin), .i_op_flag_upd(op_upd),
    .i_op_wr_en(op_wr_en), .i_op_wr_idx(op_idx), .i_ld_valid(ld_valid),
    .i_ld_idx(ld_idx), .i_ld_data(ld_data), .i_br_valid(br_valid),
    .i_br_kind(br_kind), .i_br_target(br_target), .i_br_ret(br_ret),
    .i_exc_entry(exc_entry), .i_exc_lr(exc_lr), .i_exc_vector(exc_vec),
    .i_pc_advance(pc_adv), .i_irq_async(irq_pin), .i_rd_idx(rd_idx),
    .o_rd_data(rd_data), .o_op_done(op_done), .o_op_result(op_res),
    .o_op_carry(op_carry), .o_op_ovf(op_ovf), .o_flags(flags), .o_pc(pc), .o_sp(sp),
    .o_compact_state(cstate), .o_irq(irq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  acf_ctl_model u_acf_ctl_model (
    .i_clk_sys(clk), .i_op_done(op_done), .o_op_valid(op_valid), .o_op_sub(op_sub),
    .o_op_a(op_a), .o_op_b(op_b), .o_op_cin(op_cin), .o_op_flag_upd(op_upd),
    .o_op_wr_en(op_wr_en), .o_op_wr_idx(op_idx));

  // 25 ns core clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // apb transfer held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rdv, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no local limit: only the watchdog ends a wait
    while (pready !== 1'b1)
      @(posedge clk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read port answers one edge after the index
  task automatic rd(input logic [3:0] idx, output logic [31:0] rv);
    @(posedge clk);
    rd_idx <= idx;
    @(posedge clk);
    #1;
    rv = rd_data;
  endtask : rd

  task automatic br(input int k, input logic [31:0] t);
    @(posedge clk);
    br_valid <= 1'b1;
    br_kind <= acf_br_e'(k[1:0]);
    br_target <= t;
    br_ret <= t + 32'h0000_0004;
    @(posedge clk);
    br_valid <= 1'b0;
    br_target <= ~t;
    #1;
  endtask : br

  // hang guard, far beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial
  begin
    {ld_valid, br_valid, exc_entry, irq_pin, psel, penable, pwrite, pc_adv} = '0;
    {ld_idx, rd_idx, paddr, ld_data, br_target, br_ret, exc_lr, exc_vec, pwdata} = '0;
    br_kind = ACF_BR_SIMPLE;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    chk(pc, PC_START);
    chk(sp, SP_TOP);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({31'h0, cstate}, 32'h1);
    foreach (rows[i])
    begin
      u_acf_ctl_model.issue(rows[i].s, rows[i].a, rows[i].b, rows[i].ci, 4'hf, 1'b0, 4'h0);
      chk({31'h0, op_done}, 32'h1);
      chk(op_res, rows[i].r);
      chk({31'h0, op_carry}, {31'h0, rows[i].co});
      chk({31'h0, op_ovf}, {31'h0, rows[i].ov});
      chk({28'h0, flags}, {28'h0, rows[i].r[31], rows[i].r == 32'h0, rows[i].co,
          rows[i].ov});
    end
    for (int k = 0; k < 15; k++)
      u_acf_ctl_model.issue(1'b0, 32'h0a50_0000 | k, 32'h0, 1'b0, 4'h0, 1'b1, 4'(k));
    for (int k = 0; k < 15; k++)
    begin
      rd(4'(k), v);
      chk(v, 32'h0a50_0000 | k);
    end
    chk(sp, 32'h0a50_000d);
    for (int k = 0; k < 4; k++)
    begin
      br(k, 32'h0000_2001 + k * 32'h1000);
      chk(pc, 32'h0000_2000 + k * 32'h1000);
      rd(4'he, v);
      chk(v, (k == 0) ? 32'h0a50_000e : 32'h0000_3005);
    end
    u_acf_ctl_model.issue(1'b0, 32'h0000_5001, 32'h0, 1'b0, 4'h0, 1'b1, 4'hf);
    chk(pc, 32'h0000_5000);
    @(posedge clk);
    ld_valid <= 1'b1;
    ld_idx <= 4'hf;
    ld_data <= 32'h0000_6007;
    @(posedge clk);
    ld_valid <= 1'b0;
    ld_data <= 32'hffff_9ff8;
    #1;
    chk(pc, 32'h0000_6006);
    @(posedge clk);
    exc_entry <= 1'b1;
    exc_lr <= 32'hffff_fff9;
    exc_vec <= 32'h0000_7001;
    @(posedge clk);
    exc_entry <= 1'b0;
    #1;
    chk(pc, 32'h0000_7000);
    rd(4'he, v);
    chk(v, 32'hffff_fff9);
    rd(4'hf, v);
    chk(v, 32'h0000_7000);
    // software writes flags back with the reserved field as it read it
    apb(1'b0, ACF_OFS_FLAGS, 32'h0, v, e);
    apb(1'b1, ACF_OFS_FLAGS, {4'ha, v[27:0]}, v, e);
    #1;
    chk({28'h0, flags}, 32'ha);
    u_acf_ctl_model.issue(1'b1, 32'h9, 32'h9, 1'b1, 4'b0100, 1'b0, 4'h0);
    chk({28'h0, flags}, 32'he);
    u_acf_ctl_model.issue(1'b0, 32'h7fff_ffff, 32'h1, 1'b0, 4'h0, 1'b0, 4'h0);
    apb(1'b0, ACF_OFS_FLAGS, 32'h0, v, e);
    chk(v, 32'he000_0000);
    apb(1'b0, ACF_OFS_STATUS, 32'h0, v, e);
    chk(v, 32'h7);
    chk({31'h0, irq}, 32'h0);
    irq_pin <= 1'b1;
    repeat (5) @(posedge clk);
    apb(1'b0, ACF_OFS_STATUS, 32'h0, v, e);
    chk(v, 32'hf);
    apb(1'b1, ACF_OFS_ENABLE, 32'h1, v, e);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, ACF_OFS_CLEAR, 32'h1, v, e);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, ACF_OFS_STATUS, 32'h0, v, e);
    chk(v, 32'he);
    apb(1'b0, ACF_OFS_STATE, 32'h0, v, e);
    chk(v, 32'h0100_0000);
    apb(1'b0, 8'h20, 32'h0, v, e);
    chk({e, v[30:0]}, 32'h8000_0000);
    // sequential advance steps the counter when nothing writes it
    @(posedge clk);
    pc_adv <= 1'b1;
    @(posedge clk);
    pc_adv <= 1'b0;
    #1;
    chk(pc, 32'h0000_7002);
    // second reset in mid-run restores stack pointer and counter
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(pc, PC_START);
    chk(sp, SP_TOP);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({31'h0, cstate}, 32'h1);
    test_done();
  end
endmodule : tb_add_carry_flags_core_regs
